// ===== core/asc_consts.svh
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH
// ********************************
// register offsets (byte addresses)
// ********************************
`define ASC_OFF_CTRL2 12'h000
`define ASC_OFF_SEQ 12'h004
`define ASC_OFF_STAT 12'h008
`define ASC_OFF_MASK 12'h00C
`define ASC_OFF_MODE 12'h010
// ********************************
// field positions of control register two
// ********************************
`define ASC_REF_LSB 13
`define ASC_SCAN_BIT 10
`define ASC_CHANNEL_COUNT_SELECT_LSB 8
`define ASC_BUFFER_HALF_STATUS_BIT 7
`define ASC_SEQUENCES_PER_IRQ_LSB 2
`define ASC_BUFFER_FILL_SPLIT_BIT 1
`define ASC_ALTS_BIT 0
// writable bits: 15-13, 10-8, 5-0
`define ASC_CTRL2_WMASK 16'hE73F
`define ASC_CTRL2_RESET 16'h0000
// ********************************
// status bits
// ********************************
`define ASC_ST_SEQ 0
`define ASC_ST_IRQ 1
`define ASC_ST_WIDTH 2
// mode register: bit 0 selects twelve-bit mode
`define ASC_MODE_12B 0
`endif

// ===== core/asc_pkg.sv
package asc_pkg;
  // sample-and-hold channel count selector
  typedef logic [1:0] asc_channel_count_select_t;
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b01,
    ASC_BUSY = 2'b10
  } asc_state_e;
endpackage

// ===== core/asc_seq_count.sv
`timescale 1ns/1ps
`include "asc_consts.svh"
// ********************************
// sequences-per-interrupt counter
// ********************************
module asc_seq_count (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic seq_done,
  input wire logic [3:0] sequences_per_irq,
  output logic irq_pulse,
  output logic [3:0] count
);
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic hit;

  // last sequence of the group when count reaches the field value
  assign hit = seq_done && (count_reg == sequences_per_irq);
  assign irq_pulse = hit;
  assign count = count_reg;

  // next count: wrap on hit, otherwise step per finished sequence
  always_comb begin
    count_next = count_reg;
    if (hit) begin
      count_next = 4'h0;
    end else if (seq_done) begin
      count_next = count_reg + 4'h1;
    end
  end

  // counter storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
    end
  end

  property p_irq_every_n;
    @(posedge pclk) disable iff (!presetn)
    seq_done && count_reg == sequences_per_irq |-> irq_pulse ##1 count_reg == 4'h0;
  endproperty
  a_irq_every_n: assert property (p_irq_every_n) else $error("interrupt not raised on nth sequence");
endmodule

// ===== core/asc_ctrl.sv
`timescale 1ns/1ps
`include "asc_consts.svh"
// Behaviour
// - scan enable steps scan inputs, else none
// - channel count: one, two or four channels
// - twelve-bit mode forces channel count zero
// - buffer half flag shows half being filled
// - interrupt after every (field plus one) sequences
module asc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sequencer side
  input wire logic sample_start,
  input wire logic scan_step,
  input wire logic [3:0] scan_count,
  output logic scan_inputs_enable,
  output logic [3:0] scan_index,
  output logic [3:0] channels_enabled,
  output logic [1:0] channel_count_select,
  output logic [3:0] sequences_per_irq,
  output logic buffer_fill_split,
  output logic buffer_half_status,
  output logic [2:0] reference_select,
  output logic alt_sample_select,
  output logic twelve_bit_select,
  output logic conv_irq,
  output logic irq
);
  // ********************************
  // state
  // ********************************
  logic [15:0] ctrl_reg; // writable control bits
  logic [15:0] ctrl_next;
  logic mode_reg; // twelve-bit resolution select
  logic mode_next;
  logic half_reg; // buffer half being filled
  logic half_next;
  logic [3:0] scan_reg; // current scan input
  logic [3:0] scan_next;
  logic [1:0] st_reg; // sticky events
  logic [1:0] st_next;
  logic [1:0] mask_reg; // interrupt mask
  logic [1:0] mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  asc_pkg::asc_state_e state_reg;
  asc_pkg::asc_state_e state_next;
  logic seq_done; // one sequence finished this cycle
  logic irq_pulse;
  logic [3:0] seq_count;
  logic wr_en;
  logic rd_en;
  logic [15:0] ctrl_view;

  // register address decode used only for the error response
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `ASC_OFF_CTRL2) || (a == `ASC_OFF_SEQ) || (a == `ASC_OFF_STAT) ||
              (a == `ASC_OFF_MASK) || (a == `ASC_OFF_MODE);
  endfunction

  // ********************************
  // apb slave, zero wait states
  // ********************************
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign prdata = rdata_reg;

  // ********************************
  // sequence detection
  // ********************************
  // a sequence starts at sample_start and ends only at the next sample_start;
  // finished on the edge back to idle
  always_comb begin
    state_next = state_reg;
    seq_done = 1'b0;
    unique case (state_reg)
      asc_pkg::ASC_IDLE: begin
        if (sample_start) begin
          state_next = asc_pkg::ASC_BUSY;
        end
      end
      asc_pkg::ASC_BUSY: begin
        // the sequencer pulses sample_start again to end a sequence
        if (sample_start) begin
          seq_done = 1'b1;
          state_next = asc_pkg::ASC_IDLE;
        end
      end
      default: begin
        state_next = asc_pkg::ASC_IDLE;
      end
    endcase
  end

  asc_seq_count u_count (
    .pclk(pclk),
    .presetn(presetn),
    .seq_done(seq_done),
    .sequences_per_irq(sequences_per_irq),
    .irq_pulse(irq_pulse),
    .count(seq_count)
  );
  assign conv_irq = irq_pulse;

  // ********************************
  // control field view
  // ********************************
  // channel count hidden in twelve-bit mode
  always_comb begin
    ctrl_view = ctrl_reg & `ASC_CTRL2_WMASK;
    if (mode_reg) begin
      ctrl_view[`ASC_CHANNEL_COUNT_SELECT_LSB +: 2] = 2'h0;
    end
    ctrl_view[`ASC_BUFFER_HALF_STATUS_BIT] = half_reg;
  end

  assign reference_select = ctrl_view[`ASC_REF_LSB +: 3];
  assign scan_inputs_enable = ctrl_view[`ASC_SCAN_BIT];
  assign channel_count_select = ctrl_view[`ASC_CHANNEL_COUNT_SELECT_LSB +: 2];
  assign sequences_per_irq = ctrl_view[`ASC_SEQUENCES_PER_IRQ_LSB +: 4];
  assign buffer_fill_split = ctrl_view[`ASC_BUFFER_FILL_SPLIT_BIT];
  assign alt_sample_select = ctrl_view[`ASC_ALTS_BIT];
  assign twelve_bit_select = mode_reg;
  assign buffer_half_status = half_reg;
  assign scan_index = scan_reg;

  always_comb begin
    if (channel_count_select[1]) begin
      channels_enabled = 4'hF;
    end else if (channel_count_select[0]) begin
      channels_enabled = 4'h3;
    end else begin
      channels_enabled = 4'h1;
    end
  end

  // ********************************
  // next-state of registers
  // ********************************
  always_comb begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    mask_next = mask_reg;
    half_next = half_reg;
    scan_next = scan_reg;
    st_next = st_reg;
    rdata_next = rdata_reg;
    if (wr_en && paddr == `ASC_OFF_CTRL2) begin
      ctrl_next = pwdata[15:0] & `ASC_CTRL2_WMASK;
    end
    if (wr_en && paddr == `ASC_OFF_MODE) begin
      mode_next = pwdata[`ASC_MODE_12B];
    end
    if (wr_en && paddr == `ASC_OFF_MASK) begin
      mask_next = pwdata[1:0];
    end
    // halves only swap in split mode
    if (irq_pulse && buffer_fill_split) begin
      half_next = !half_reg;
    end else if (!buffer_fill_split) begin
      half_next = 1'b0;
    end
    if (!scan_inputs_enable || sample_start && state_reg == asc_pkg::ASC_IDLE) begin
      scan_next = 4'h0;
    end else if (scan_step) begin
      scan_next = (scan_reg >= scan_count) ? 4'h0 : scan_reg + 4'h1;
    end
    // reading status clears only the bits that the read reported, since an event
    // landing between setup and access would otherwise be lost; a new event wins over the clear
    if (rd_en && paddr == `ASC_OFF_STAT) begin
      st_next = st_reg & ~rdata_reg[1:0];
    end
    if (seq_done) begin
      st_next[`ASC_ST_SEQ] = 1'b1;
    end
    if (irq_pulse) begin
      st_next[`ASC_ST_IRQ] = 1'b1;
    end
    // read data captured during the setup phase
    if (psel && !penable && !pwrite) begin
      rdata_next = 32'h0000_0000;
      unique case (paddr)
        `ASC_OFF_CTRL2: rdata_next = {16'h0000, ctrl_view};
        `ASC_OFF_SEQ: rdata_next = {28'h0000000, seq_count};
        `ASC_OFF_STAT: rdata_next = {30'h00000000, st_reg};
        `ASC_OFF_MASK: rdata_next = {30'h00000000, mask_reg};
        `ASC_OFF_MODE: rdata_next = {31'h00000000, mode_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `ASC_CTRL2_RESET;
      mode_reg <= 1'b0;
      mask_reg <= 2'h0;
      half_reg <= 1'b0;
      scan_reg <= 4'h0;
      st_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      state_reg <= asc_pkg::ASC_IDLE;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      half_reg <= half_next;
      scan_reg <= scan_next;
      st_reg <= st_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
    end
  end

  // level interrupt while any unmasked sticky bit is set
  assign irq = |(st_reg & mask_reg);

  // ********************************
  // assertions
  // ********************************
  // scan off holds zero
  property p_no_scan;
    @(posedge pclk) disable iff (!presetn)
    !scan_inputs_enable |=> scan_index == 4'h0;
  endproperty
  a_no_scan: assert property (p_no_scan) else $error("scan index moved with scan disabled");

  property p_chan_map;
    @(posedge pclk) disable iff (!presetn)
    channels_enabled == (channel_count_select[1] ? 4'hF : (channel_count_select[0] ? 4'h3 : 4'h1));
  endproperty
  a_chan_map: assert property (p_chan_map) else $error("channel enables wrong");

  property p_twelve;
    @(posedge pclk) disable iff (!presetn)
    twelve_bit_select |-> channels_enabled == 4'h1 && channel_count_select == 2'h0;
  endproperty
  a_twelve: assert property (p_twelve) else $error("channel count visible in twelve-bit mode");

  property p_half_toggle;
    @(posedge pclk) disable iff (!presetn)
    irq_pulse && buffer_fill_split |=> buffer_half_status != $past(buffer_half_status);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("buffer half did not swap");

  property p_single_mode;
    @(posedge pclk) disable iff (!presetn)
    !buffer_fill_split |=> !buffer_half_status;
  endproperty
  a_single_mode: assert property (p_single_mode) else $error("half flag set in single mode");

  property p_unimpl;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg & ~`ASC_CTRL2_WMASK) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit stored");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    irq_pulse && mask_reg[`ASC_ST_IRQ] |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output not raised");

  property p_half_hold;
    @(posedge pclk) disable iff (!presetn)
    buffer_fill_split && !irq_pulse |=> $stable(buffer_half_status);
  endproperty
  a_half_hold: assert property (p_half_hold) else $error("buffer half swapped without interrupt");

  // a busy sequence ended by a second start pulse
  sequence s_seq_end;
    (state_reg == asc_pkg::ASC_BUSY) && sample_start;
  endsequence
  // the ending sequence closes a group of sequences
  sequence s_group_end;
    s_seq_end ##0 (seq_count == sequences_per_irq);
  endsequence

  property p_group_irq;
    @(posedge pclk) disable iff (!presetn)
    s_group_end |-> conv_irq ##1 (seq_count == 4'h0);
  endproperty
  a_group_irq: assert property (p_group_irq) else $error("group end without interrupt");

  property p_no_early_irq;
    @(posedge pclk) disable iff (!presetn)
    s_seq_end ##0 (seq_count != sequences_per_irq) |-> !conv_irq ##1 (seq_count == $past(seq_count) + 4'h1);
  endproperty
  a_no_early_irq: assert property (p_no_early_irq) else $error("interrupt inside a group");
endmodule

// ===== dv/adc_sequence_control_two_test.sv
`timescale 1ns/1ps
`include "asc_consts.svh"
// ********************************
// bench for control register two
// ********************************
module adc_sequence_control_two_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sample_start = 1'b0;
  logic scan_step = 1'b0;
  logic [3:0] scan_count = 4'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err;
  logic scan_inputs_enable, buffer_fill_split, buffer_half_status, alt_sample_select, twelve_bit_select, conv_irq, irq;
  logic [3:0] scan_index, channels_enabled, sequences_per_irq;
  logic [1:0] channel_count_select;
  logic [2:0] reference_select;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  // expected channel enables per count code
  logic [3:0] chan_exp [4] = '{4'h1, 4'h3, 4'hF, 4'hF};

  asc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_start(sample_start), .scan_step(scan_step), .scan_count(scan_count),
    .scan_inputs_enable(scan_inputs_enable), .scan_index(scan_index), .channels_enabled(channels_enabled),
    .channel_count_select(channel_count_select), .sequences_per_irq(sequences_per_irq),
    .buffer_fill_split(buffer_fill_split), .buffer_half_status(buffer_half_status),
    .reference_select(reference_select), .alt_sample_select(alt_sample_select),
    .twelve_bit_select(twelve_bit_select), .conv_irq(conv_irq), .irq(irq));

  // 40 ns clock
  always #20 pclk = ~pclk;

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  // one comparison; the caller names what is being judged
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; waits for pready rather than assuming zero wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(q, exp, msg);
  endtask

  task automatic step();
    @(posedge pclk);
    scan_step <= 1'b1;
    @(posedge pclk);
    scan_step <= 1'b0;
    #1;
  endtask

  // start pulse, then end pulse; interrupt is judged during the end pulse
  task automatic seq(input logic exp_irq);
    @(posedge pclk);
    sample_start <= 1'b1;
    @(posedge pclk);
    sample_start <= 1'b0;
    @(posedge pclk);
    sample_start <= 1'b1;
    #1;
    chk(conv_irq, exp_irq, "conversion interrupt");
    @(posedge pclk);
    sample_start <= 1'b0;
    #1;
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // values straight after reset
  task automatic test_reset();
    rd(`ASC_OFF_CTRL2, 32'h0, "control after reset");
    chk(channels_enabled, 4'h1, "channels after reset");
  endtask

  // all ones: unimplemented and read-only bits must stay zero
  task automatic test_unimpl();
    apb(1'b1, `ASC_OFF_CTRL2, 32'h0000FFFF);
    rd(`ASC_OFF_CTRL2, 32'h0000E73F, "writable bits only");
    chk({scan_inputs_enable, reference_select, alt_sample_select}, 5'h1F, "field outputs");
  endtask

  // every channel count code
  task automatic test_chan_count();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `ASC_OFF_CTRL2, 32'(i) << `ASC_CHANNEL_COUNT_SELECT_LSB);
      chk(channels_enabled, chan_exp[i], "channel enables");
    end
  endtask

  // twelve-bit mode hides the channel count, ten-bit mode shows it again
  task automatic test_twelve_bit();
    apb(1'b1, `ASC_OFF_MODE, 32'h1);
    chk({twelve_bit_select, channel_count_select, channels_enabled}, 7'h41, "twelve-bit view");
    rd(`ASC_OFF_CTRL2, 32'h0, "count reads zero");
    apb(1'b1, `ASC_OFF_MODE, 32'h0);
    chk({twelve_bit_select, channel_count_select}, 3'h3, "ten-bit view");
  endtask

  // scanning steps, wraps after the last input, and returns to the first input when disabled
  task automatic test_scan();
    @(posedge pclk);
    scan_count <= 4'h2;
    apb(1'b1, `ASC_OFF_CTRL2, 32'h00000400);
    step();
    chk(scan_index, 4'h1, "first scan step");
    step();
    chk(scan_index, 4'h2, "second scan step");
    step();
    chk(scan_index, 4'h0, "scan wraps after last");
    step();
    apb(1'b1, `ASC_OFF_CTRL2, 32'h0);
    step();
    chk(scan_index, 4'h0, "scan off returns to first input");
  endtask

  // split mode, interrupt every third sequence
  task automatic test_split_irq();
    apb(1'b1, `ASC_OFF_MASK, 32'h2);
    apb(1'b1, `ASC_OFF_CTRL2, 32'h0000000A);
    chk({buffer_fill_split, sequences_per_irq}, 5'h12, "split and group fields");
    seq(1'b0);
    rd(`ASC_OFF_SEQ, 32'h1, "sequence count");
    chk(irq, 1'b0, "masked status");
    seq(1'b0);
    chk(buffer_half_status, 1'b0, "first half");
    seq(1'b1);
    chk({buffer_half_status, irq}, 2'h3, "second half and interrupt");
    rd(`ASC_OFF_CTRL2, 32'h0000008A, "half flag readback");
    rd(`ASC_OFF_STAT, 32'h3, "sticky status");
    chk(irq, 1'b0, "status cleared by read");
    rd(`ASC_OFF_STAT, 32'h0, "status empty");
  endtask

  // every sequence in split mode, then sixteen in single-buffer mode
  task automatic test_single_irq();
    apb(1'b1, `ASC_OFF_CTRL2, 32'h00000002);
    seq(1'b1);
    chk(buffer_half_status, 1'b0, "back to first half");
    apb(1'b1, `ASC_OFF_CTRL2, 32'h0000003C);
    for (int i = 0; i < 16; i++) begin
      seq(i == 15);
    end
    chk(buffer_half_status, 1'b0, "half flag in single mode");
  endtask

  // unmapped address is refused
  task automatic test_unmapped();
    apb(1'b1, 12'h014, 32'hFFFFFFFF);
    rd(12'h014, 32'h0, "unmapped reads zero");
    chk(err, 1'b1, "unmapped error response");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_unimpl();
    test_chan_count();
    test_twelve_bit();
    test_scan();
    test_split_irq();
    test_single_irq();
    test_unmapped();
    end_of_test();
  end
endmodule
